/* File: cotp_pkg.sv */
// constants shared by the operand transfer engine
// assumes one 100 MHz clock domain, AHB-Lite register port
package cotp_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPWORD = 8'h04;
  localparam logic [7:0] REG_SCAN_PROGRAM_COUNTER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TEMPEA = 8'h10;
  localparam logic [7:0] REG_RFIDX = 8'h14;
  localparam logic [7:0] REG_RFDATA = 8'h18;
  // control word fields
  localparam int CTL_LEN_LSB = 0;
  localparam int CTL_CLS_LSB = 8;
  localparam int CTL_DR_BIT = 11;
  localparam int CTL_CA_BIT = 12;
  localparam int CTL_KIND_LSB = 13;
  localparam int CTL_COND_BIT = 16;
  localparam int CTL_SUP_BIT = 17;
  localparam int CTL_W = 18;
  // status word fields
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_RES_LSB = 1;
  localparam int STS_TVAL_BIT = 3;
  // reset value, abort mask word, stack pointer register number
  localparam logic [31:0] SCAN_PROGRAM_COUNTER_RST = 32'h0000_0000;
  localparam logic [31:0] ABORT_MASK = 32'h0000_0001;
  localparam logic [2:0] SP_REG_NUM = 3'h7;
  // function codes
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;
  // result codes
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_PV = 2'h1;
  localparam logic [1:0] RES_FLINE = 2'h2;
  // valid address classes
  localparam logic [2:0] CLS_CTRL_ALT = 3'h0;
  localparam logic [2:0] CLS_DATA_ALT = 3'h1;
  localparam logic [2:0] CLS_MEM_ALT = 3'h2;
  localparam logic [2:0] CLS_ALT = 3'h3;
  localparam logic [2:0] CLS_CTRL = 3'h4;
  localparam logic [2:0] CLS_DATA = 3'h5;
  localparam logic [2:0] CLS_MEM = 3'h6;
  localparam logic [2:0] CLS_ANY = 3'h7;
  typedef enum logic [1:0] {
    KIND_EVAL = 2'h0, KIND_WPREV = 2'h1, KIND_TAKE = 2'h2
  } cotp_kind_t;
  typedef enum logic [2:0] {
    SP_MEM = 3'h0, SP_IFETCH = 3'h1, SP_CIR_OPND = 3'h2,
    SP_CIR_OPADDR = 3'h3, SP_CIR_CTRL = 3'h4
  } cotp_space_t;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_CHECK = 11'h002, ST_RDREG = 11'h004,
    ST_EXT = 11'h008, ST_RDX = 11'h010, ST_CALC = 11'h020,
    ST_SRC = 11'h040, ST_DST = 11'h080, ST_POST = 11'h100,
    ST_TAKEA = 11'h200, ST_ABORT = 11'h400
  } cotp_st_t;
endpackage

/* File: cotp_ea_class.sv */
// addressing mode classifier for the operand engine
// assumes mode and register fields are stable while read
`timescale 1ns/1ps
module cotp_ea_class import cotp_pkg::*; (
  // mode under test
  input wire logic [2:0] mode,
  input wire logic [2:0] rnum,
  input wire logic [2:0] cls,
  // verdicts
  output logic class_ok,
  output logic alterable,
  output logic reg_direct,
  output logic immediate
);
  ////////////////////////////////////////////////////////////////
  // membership per mode; modes 7/5..7/7 belong to no class
  always_comb begin
    logic valid, dn, an, pcrel, data_m, mem_m, ctl_m;
    valid = !(mode == 3'h7 && rnum > 3'h4);
    dn = (mode == 3'h0);
    an = (mode == 3'h1);
    pcrel = (mode == 3'h7) && (rnum == 3'h2 || rnum == 3'h3);
    immediate = (mode == 3'h7) && (rnum == 3'h4);
    reg_direct = dn || an;
    alterable = valid && !pcrel && !immediate;
    data_m = valid && !an;
    mem_m = valid && !dn && !an;
    ctl_m = mem_m && mode != 3'h3 && mode != 3'h4 && !immediate;
    case (cls)
      CLS_CTRL_ALT: class_ok = ctl_m && alterable;
      CLS_DATA_ALT: class_ok = data_m && alterable;
      CLS_MEM_ALT: class_ok = mem_m && alterable;
      CLS_ALT: class_ok = alterable;
      CLS_CTRL: class_ok = ctl_m;
      CLS_DATA: class_ok = data_m;
      CLS_MEM: class_ok = mem_m;
      default: class_ok = valid;
    endcase
  end
endmodule

/* File: cotp_regfile.sv */
// programming-model registers: d0..d7 at 0..7, a0..a7 at 8..15
// assumes one write and one read port; read data is registered
`timescale 1ns/1ps
module cotp_regfile (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  // read port
  input wire logic [3:0] raddr,
  output logic [31:0] rdata
);
  typedef struct packed {
    logic [15:0][31:0] mem;
    logic [31:0] rdata;
  } cotp_rf_t;
  cotp_rf_t s, n;
  ////////////////////////////////////////////////////////////////
  // read sees the old word on a same-address write
  always_comb begin
    n = s;
    n.rdata = s.mem[raddr];
    if (we) begin
      n.mem[waddr] = wdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign rdata = s.rdata;
endmodule

/* File: cotp_engine.sv */
// operand transfer engine: evaluate-and-transfer, write-to-previous,
// take-address primitives, driven over an AHB-Lite register port
// assumes the transfer port partner pulses xf_ack once per request
`timescale 1ns/1ps
// Contract
// - evaluate-transfer in conditional category: protocol violation
// - three-bit class field selects allowed modes
// - mode outside class: abort mask, F-line
// - write to unalterable address: protocol violation
// - register direct allows lengths 1,2,4 only
// - memory modes take lengths 0 to 255
// - immediate: one or even, toward coprocessor
// - extension words at scan counter, step two
// - direction bit: 0 to coprocessor, 1 from
// - predecrement first; stack byte steps two
// - postincrement after; stack byte steps two
// - every issue recomputes address, fresh words
// - address register sign-extends, data merges low
// - write-previous: general only, lengths 0 to 255
// - write-previous uses stored temporary address
// - write-previous: supervisor-bit space, no checks
// - long parts ascending, short remainder last
// - write-previous leaves programming registers untouched
// - taken address never replaces stored address
// - ordinary interruptible cycles, arbitration allowed between
// - take-address: conditional needs come-again bit
// - take-address: 32-bit address, long parts ascending
// - take-address space follows supervisor bit
module cotp_engine import cotp_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // transfer port to memory, instruction stream and interface regs
  output logic xf_req,
  output logic [2:0] xf_space,
  output logic xf_we,
  output logic [31:0] xf_addr,
  output logic [2:0] xf_size,
  output logic [2:0] xf_fc,
  output logic [31:0] xf_wdata,
  input wire logic xf_ack,
  input wire logic [31:0] xf_rdata
);
  typedef struct packed {
    cotp_st_t st;
    cotp_kind_t kind;
    logic [7:0] len;
    logic [2:0] cls;
    logic dr, ca, cond, sup;
    logic [5:0] opword;
    logic [CTL_W-1:0] ctrl;
    logic [31:0] scan_pc, temp_ea, ea, hold, regval;
    logic temp_valid;
    logic [7:0] remain;
    logic [1:0] ext_cnt, result;
    logic [3:0] rfidx;
    logic xf_req, xf_we;
    cotp_space_t xf_space;
    logic [31:0] xf_addr, xf_wdata;
    logic [2:0] xf_size, xf_fc;
    logic rdy;
    logic [31:0] hrdata;
    logic [7:0] baddr;
    logic bwr;
    logic rf_we;
    logic [3:0] rf_waddr;
    logic [31:0] rf_wdata;
  } cotp_state_t;
  cotp_state_t s, n;
  logic [31:0] rf_rdata;
  logic [3:0] rf_raddr;
  logic class_ok, alterable, regdir, imm;
  logic [2:0] mode, rnum;
  logic is_rd, is_im;
  logic [7:0] part, impart, adj;
  logic [2:0] fc_data;
  ////////////////////////////////////////////////////////////////
  // helpers
  assign mode = s.opword[5:3];
  assign rnum = s.opword[2:0];
  assign is_rd = (s.kind == KIND_EVAL) && regdir;
  assign is_im = (s.kind == KIND_EVAL) && imm;
  assign part = (s.remain >= 8'h04) ? 8'h04 : s.remain;
  assign impart = (s.remain >= 8'h02) ? 8'h02 : 8'h01;
  // stack pointer keeps word alignment on byte operands
  assign adj = (s.len == 8'h01 && rnum == SP_REG_NUM) ? 8'h02 : s.len;
  assign fc_data = s.sup ? FC_SUP_DATA : FC_USER_DATA;
  // index register number sits in the extension word
  assign rf_raddr = (s.st == ST_RDX) ? s.hold[15:12] :
    (s.st == ST_IDLE) ? s.rfidx : {mode != 3'h0, rnum};
  ////////////////////////////////////////////////////////////////
  // submodules
  cotp_ea_class u_cls (
    .mode(mode),
    .rnum(rnum),
    .cls(s.cls),
    .class_ok(class_ok),
    .alterable(alterable),
    .reg_direct(regdir),
    .immediate(imm)
  );
  cotp_regfile u_rf (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(s.rf_we),
    .waddr(s.rf_waddr),
    .wdata(s.rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );
  ////////////////////////////////////////////////////////////////
  // next state: bus slave and engine
  always_comb begin
    logic [31:0] cea, xv;
    cea = s.ea;
    xv = s.hold[11] ? rf_rdata : {{16{rf_rdata[15]}}, rf_rdata[15:0]};
    n = s;
    n.rf_we = 1'b0;
    n.rdy = 1'b1;
    n.bwr = 1'b0;
    // address phase: read data is prepared here so it leaves a flop
    if (hsel && htrans[1] && hready) begin
      n.baddr = haddr[7:0];
      n.bwr = hwrite;
      if (haddr[7:0] == REG_CTRL) begin
        n.hrdata = {14'h0, s.ctrl};
      end else if (haddr[7:0] == REG_OPWORD) begin
        n.hrdata = {26'h0, s.opword};
      end else if (haddr[7:0] == REG_SCAN_PROGRAM_COUNTER) begin
        n.hrdata = s.scan_pc;
      end else if (haddr[7:0] == REG_STATUS) begin
        n.hrdata = {28'h0, s.temp_valid, s.result, s.st != ST_IDLE};
      end else if (haddr[7:0] == REG_TEMPEA) begin
        n.hrdata = s.temp_ea;
      end else if (haddr[7:0] == REG_RFIDX) begin
        n.hrdata = {28'h0, s.rfidx};
      end else if (haddr[7:0] == REG_RFDATA) begin
        n.hrdata = rf_rdata;
      end else begin
        n.hrdata = 32'h0;
      end
    end
    // data phase writes; setup registers are frozen while busy
    if (s.bwr && s.st == ST_IDLE) begin
      if (s.baddr == REG_CTRL) begin
        n.ctrl = hwdata[CTL_W-1:0];
        n.len = hwdata[CTL_LEN_LSB +: 8];
        n.cls = hwdata[CTL_CLS_LSB +: 3];
        n.dr = hwdata[CTL_DR_BIT];
        n.ca = hwdata[CTL_CA_BIT];
        n.kind = cotp_kind_t'(hwdata[CTL_KIND_LSB +: 2]);
        n.cond = hwdata[CTL_COND_BIT];
        n.sup = hwdata[CTL_SUP_BIT];
        n.st = ST_CHECK;
      end else if (s.baddr == REG_OPWORD) begin
        n.opword = hwdata[5:0];
      end else if (s.baddr == REG_SCAN_PROGRAM_COUNTER) begin
        n.scan_pc = hwdata;
      end else if (s.baddr == REG_RFIDX) begin
        n.rfidx = hwdata[3:0];
      end else if (s.baddr == REG_RFDATA) begin
        n.rf_we = 1'b1;
        n.rf_waddr = s.rfidx;
        n.rf_wdata = hwdata;
      end
    end
    case (s.st)
      ST_CHECK: begin
        n.st = ST_IDLE;
        n.result = RES_PV;
        if (s.kind == KIND_EVAL) begin
          if (s.cond) begin
          end else if (!class_ok) begin
            n.st = ST_ABORT;
            n.result = RES_OK;
          end else if (s.dr && !alterable) begin
          end else if (regdir && !(s.len == 8'h01 || s.len == 8'h02 ||
              s.len == 8'h04)) begin
          end else if (imm && (s.dr || (s.len != 8'h01 && s.len[0]))) begin
          end else begin
            n.st = ST_RDREG;
            n.result = RES_OK;
          end
        end else if (s.kind == KIND_WPREV) begin
          if (!s.cond) begin
            n.ea = s.temp_ea;
            n.dr = 1'b1;
            n.remain = s.len;
            n.st = ST_SRC;
            n.result = RES_OK;
          end
        end else if (s.kind == KIND_TAKE) begin
          if (!(s.cond && !s.ca)) begin
            n.st = ST_TAKEA;
            n.result = RES_OK;
          end
        end
      end
      ST_RDREG: begin
        n.regval = rf_rdata;
        n.ea = rf_rdata;
        n.ext_cnt = 2'h1;
        n.remain = s.len;
        if (mode == 3'h0 || mode == 3'h1) begin
          n.temp_valid = 1'b0;
          n.st = ST_SRC;
        end else if (mode == 3'h4) begin
          n.ea = rf_rdata - {24'h0, adj};
          n.st = ST_CALC;
        end else if (mode == 3'h2 || mode == 3'h3) begin
          n.st = ST_CALC;
        end else if (imm) begin
          n.st = ST_SRC;
        end else begin
          n.ext_cnt = (mode == 3'h7 && rnum == 3'h1) ? 2'h2 : 2'h1;
          n.st = ST_EXT;
        end
      end
      ST_EXT: begin
        if (!s.xf_req) begin
          n.xf_req = 1'b1;
          n.xf_we = 1'b0;
          n.xf_space = SP_IFETCH;
          n.xf_addr = s.scan_pc;
          n.xf_size = 3'h2;
          n.xf_fc = s.sup ? FC_SUP_PROG : FC_USER_PROG;
        end else if (xf_ack) begin
          n.xf_req = 1'b0;
          n.hold = {s.hold[15:0], xf_rdata[15:0]};
          n.scan_pc = s.scan_pc + 32'h2;
          n.ext_cnt = s.ext_cnt - 2'h1;
          if (s.ext_cnt == 2'h1) begin
            n.st = (mode == 3'h6 || (mode == 3'h7 && rnum == 3'h3)) ? ST_RDX : ST_CALC;
          end
        end
      end
      ST_RDX: begin
        n.st = ST_CALC;
      end
      ST_CALC: begin
        if (mode == 3'h5) begin
          cea = s.regval + {{16{s.hold[15]}}, s.hold[15:0]};
        end else if (mode == 3'h6) begin
          cea = s.regval + {{24{s.hold[7]}}, s.hold[7:0]} + xv;
        end else if (mode == 3'h7 && rnum == 3'h0) begin
          cea = {{16{s.hold[15]}}, s.hold[15:0]};
        end else if (mode == 3'h7 && rnum == 3'h1) begin
          cea = s.hold;
        end else if (mode == 3'h7 && rnum == 3'h2) begin
          cea = s.scan_pc - 32'h2 + {{16{s.hold[15]}}, s.hold[15:0]};
        end else if (mode == 3'h7 && rnum == 3'h3) begin
          cea = s.scan_pc - 32'h2 + {{24{s.hold[7]}}, s.hold[7:0]} + xv;
        end
        n.ea = cea;
        n.temp_ea = cea;
        n.temp_valid = 1'b1;
        if (mode == 3'h4) begin
          n.rf_we = 1'b1;
          n.rf_waddr = {1'b1, rnum};
          n.rf_wdata = cea;
        end
        n.st = ST_SRC;
      end
      ST_SRC: begin
        if (s.remain == 8'h00) begin
          n.st = ST_POST;
        end else if (is_rd && !s.dr) begin
          n.hold = s.regval;
          n.st = ST_DST;
        end else if (!s.xf_req) begin
          n.xf_req = 1'b1;
          n.xf_we = 1'b0;
          n.xf_space = is_im ? SP_IFETCH : s.dr ? SP_CIR_OPND : SP_MEM;
          n.xf_addr = is_im ? s.scan_pc : s.ea;
          n.xf_size = is_im ? 3'h2 : is_rd ? s.len[2:0] : part[2:0];
          n.xf_fc = is_im ? (s.sup ? FC_SUP_PROG : FC_USER_PROG) : fc_data;
        end else if (xf_ack) begin
          n.xf_req = 1'b0;
          n.hold = xf_rdata;
          if (is_im) begin
            n.scan_pc = s.scan_pc + 32'h2;
          end
          n.st = ST_DST;
        end
      end
      ST_DST: begin
        if (is_rd && s.dr) begin
          n.rf_we = 1'b1;
          n.rf_waddr = {mode == 3'h1, rnum};
          if (s.len == 8'h04) begin
            n.rf_wdata = s.hold;
          end else if (mode == 3'h1) begin
            n.rf_wdata = (s.len == 8'h01) ? {{24{s.hold[7]}}, s.hold[7:0]} :
              {{16{s.hold[15]}}, s.hold[15:0]};
          end else begin
            n.rf_wdata = (s.len == 8'h01) ? {s.regval[31:8], s.hold[7:0]} :
              {s.regval[31:16], s.hold[15:0]};
          end
          n.remain = 8'h00;
          n.st = ST_SRC;
        end else if (!s.xf_req) begin
          n.xf_req = 1'b1;
          n.xf_we = 1'b1;
          n.xf_space = s.dr ? SP_MEM : SP_CIR_OPND;
          n.xf_addr = s.ea;
          n.xf_size = is_rd ? s.len[2:0] : is_im ? impart[2:0] : part[2:0];
          n.xf_wdata = s.hold;
          n.xf_fc = fc_data;
        end else if (xf_ack) begin
          n.xf_req = 1'b0;
          n.ea = s.ea + {24'h0, part};
          n.remain = is_rd ? 8'h00 : is_im ? s.remain - impart : s.remain - part;
          n.st = ST_SRC;
        end
      end
      ST_POST: begin
        if (s.kind == KIND_EVAL && mode == 3'h3) begin
          n.rf_we = 1'b1;
          n.rf_waddr = {1'b1, rnum};
          n.rf_wdata = s.regval + {24'h0, adj};
        end
        n.st = ST_IDLE;
      end
      ST_TAKEA: begin
        if (!s.xf_req) begin
          n.xf_req = 1'b1;
          n.xf_we = 1'b0;
          n.xf_space = SP_CIR_OPADDR;
          n.xf_size = 3'h4;
          n.xf_fc = fc_data;
        end else if (xf_ack) begin
          n.xf_req = 1'b0;
          n.ea = xf_rdata;
          n.remain = s.len;
          n.st = ST_SRC;
        end
      end
      ST_ABORT: begin
        if (!s.xf_req) begin
          n.xf_req = 1'b1;
          n.xf_we = 1'b1;
          n.xf_space = SP_CIR_CTRL;
          n.xf_size = 3'h2;
          n.xf_wdata = ABORT_MASK;
          n.xf_fc = fc_data;
        end else if (xf_ack) begin
          n.xf_req = 1'b0;
          n.result = RES_FLINE;
          n.st = ST_IDLE;
        end
      end
      default: begin
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.scan_pc <= SCAN_PROGRAM_COUNTER_RST;
    end else begin
      s <= n;
    end
  end
  assign hreadyout = s.rdy;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign xf_req = s.xf_req;
  assign xf_space = s.xf_space;
  assign xf_we = s.xf_we;
  assign xf_addr = s.xf_addr;
  assign xf_size = s.xf_size;
  assign xf_fc = s.xf_fc;
  assign xf_wdata = s.xf_wdata;
  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire chk_eval = s.st == ST_CHECK && s.kind == KIND_EVAL;
  sequence abort_entry;
    chk_eval && !s.cond && !class_ok;
  endsequence
  sequence abort_write;
    s.xf_req && s.xf_space == SP_CIR_CTRL && s.xf_wdata == ABORT_MASK;
  endsequence
  a_cond_eval_pv: assert property (chk_eval && s.cond |=>
    s.st == ST_IDLE && s.result == RES_PV) else $error("cond eval not refused");
  a_abort_mask: assert property (abort_entry |=> ##1 abort_write)
    else $error("abort mask not written");
  a_unalt_write: assert property (chk_eval && !s.cond && class_ok && s.dr &&
    !alterable |=> s.result == RES_PV) else $error("unalterable write taken");
  a_regdir_len: assert property (chk_eval && !s.cond && class_ok && regdir &&
    s.len == 8'h03 |=> s.result == RES_PV) else $error("bad reg length taken");
  a_imm_dir: assert property (chk_eval && !s.cond && class_ok && imm && s.dr
    |=> s.st == ST_IDLE) else $error("immediate toward memory taken");
  a_scan_step: assert property (s.st == ST_EXT && s.xf_req && xf_ack |=>
    s.scan_pc == $past(s.scan_pc) + 32'h2) else $error("scan step wrong");
  a_long_part: assert property ($rose(s.xf_req) && s.xf_space == SP_MEM &&
    s.remain >= 8'h04 |-> s.xf_size == 3'h4) else $error("part not long");
  a_wprev_addr: assert property (s.st == ST_CHECK && s.kind == KIND_WPREV &&
    !s.cond |=> s.ea == $past(s.temp_ea) && s.st == ST_SRC) else $error("wprev addr");
  a_wprev_keep: assert property (s.kind == KIND_WPREV && s.st != ST_IDLE
    |=> !s.rf_we) else $error("wprev touched registers");
  a_take_keep: assert property (s.kind == KIND_TAKE && s.st != ST_IDLE &&
    s.st != ST_CHECK |=> $stable(s.temp_ea)) else $error("take replaced temp");
  a_take_fc: assert property (s.st == ST_TAKEA && s.xf_req |->
    s.xf_fc == (s.sup ? FC_SUP_DATA : FC_USER_DATA)) else $error("take fc wrong");
endmodule

/* File: cotp_xfer_partner.sv */
// far-side responder: memory, instruction stream and interface registers
// assumes one request at a time; acks promptly or after three idle cycles
`timescale 1ns/1ps
module cotp_xfer_partner import cotp_pkg::*; #(
  parameter logic [31:0] TAKE_ADDR = 32'h0000_2000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request side
  input wire logic xf_req,
  input wire logic [2:0] xf_space,
  input wire logic [31:0] xf_addr,
  input wire logic slow,
  // answer side
  output logic xf_ack,
  output logic [31:0] xf_rdata
);
  logic [1:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle ack; idle data inverts so stale data never matches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xf_ack <= 1'b0;
      wait_cnt <= 2'h0;
      xf_rdata <= 32'h0;
    end else if (xf_req && !xf_ack && (!slow || wait_cnt == 2'h3)) begin
      xf_ack <= 1'b1;
      wait_cnt <= 2'h0;
      case (xf_space)
        SP_CIR_OPADDR: xf_rdata <= TAKE_ADDR;
        SP_IFETCH: xf_rdata <= 32'h0000_0010;
        SP_CIR_OPND: xf_rdata <= 32'h1234_80f0;
        default: xf_rdata <= xf_addr ^ 32'h5a5a_0000;
      endcase
    end else begin
      xf_ack <= 1'b0;
      wait_cnt <= (xf_req && !xf_ack) ? wait_cnt + 2'h1 : 2'h0;
      xf_rdata <= ~xf_rdata;
    end
  end
endmodule

/* File: coprocessor_operand_transfer_primitives_tb_top.sv */
// self-checking bench for the operand transfer engine
// assumes an ahb-lite master here and the responder on the transfer port
`timescale 1ns/1ps
module coprocessor_operand_transfer_primitives_tb_top import cotp_pkg::*;;
  localparam logic [31:0] TAKE_A = 32'h0000_3000;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, dp_chk = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h7c8c, ab_data = 32'h0;
  logic hreadyout, hresp, xf_req, xf_we, xf_ack, m_we;
  logic [31:0] hrdata, xf_addr, xf_wdata, xf_rdata, rd_q, a_val, m_first;
  logic [2:0] xf_space, xf_size, xf_fc, m_fc, m_size;
  logic [63:0] exp_q[$];
  int error_cnt = 0, checked = 0, m_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 hclk = ~hclk;
  // one slave: its ready is the bus ready
  cotp_engine DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xf_req(xf_req),
    .xf_space(xf_space), .xf_we(xf_we), .xf_addr(xf_addr), .xf_size(xf_size),
    .xf_fc(xf_fc), .xf_wdata(xf_wdata), .xf_ack(xf_ack), .xf_rdata(xf_rdata));
  cotp_xfer_partner #(.TAKE_ADDR(TAKE_A)) far_end (.hclk(hclk), .hresetn(hresetn),
    .xf_req(xf_req), .xf_space(xf_space), .xf_addr(xf_addr), .slow(slow),
    .xf_ack(xf_ack), .xf_rdata(xf_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one transfer, held until ready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dp_chk <= c;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
    dp_chk <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({e & m, m});
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic res(input logic [1:0] r);
    rdx(REG_STATUS, {29'h0, r, 1'b0}, 32'h6);
  endtask
  task automatic setreg(input logic [3:0] i, input logic [31:0] v);
    wr(REG_RFIDX, {28'h0, i});
    wr(REG_RFDATA, v);
  endtask
  // index settles two cycles before the read
  task automatic getreg(input logic [3:0] i, input logic [31:0] v);
    wr(REG_RFIDX, {28'h0, i});
    repeat (2) @(posedge hclk);
    rdx(REG_RFDATA, v, 32'hffff_ffff);
  endtask
  // start a primitive, poll until idle
  task automatic op(input logic [7:0] len, input logic [2:0] cls, input logic dr,
      input logic [1:0] kind, input logic ca, input logic cond, input logic sup);
    m_cnt = 0;
    slow <= rnd[0];
    rnd = xs(rnd);
    wr(REG_CTRL, {14'h0, sup, cond, 1'b0, kind, ca, dr, cls, len});
    do bus(1'b0, REG_STATUS, 32'h0, 1'b0); while (rd_q[STS_BUSY_BIT] !== 1'b0);
  endtask
  task automatic ev(input logic [7:0] len, input logic dr);
    op(len, CLS_ANY, dr, KIND_EVAL, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // oldest note against each checked data phase
  always @(posedge hclk) begin
    if (dp_chk && exp_q.size() > 0) begin
      check("hrdata", hrdata & exp_q[0][31:0], exp_q[0][63:32]);
      void'(exp_q.pop_front());
    end
  end
  // monitor: first address, parts, last attributes, abort data
  always @(posedge hclk) begin
    if (xf_req && xf_ack && xf_space == SP_MEM) begin
      if (m_cnt == 0) m_first = xf_addr;
      m_cnt++;
      m_we = xf_we;
      m_fc = xf_fc;
      m_size = xf_size;
    end
    if (xf_req && xf_ack && xf_space == SP_CIR_CTRL && xf_we) ab_data = xf_wdata;
  end
  // watchdog far past the longest run
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    $display("Error watchdog expired");
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rnd = xs(rnd);
    a_val = 32'h0000_1000 + {20'h0, rnd[11:2], 2'h0};
    rdx(REG_STATUS, 32'h0, 32'hffff_ffff);
    rdx(REG_SCAN_PROGRAM_COUNTER, SCAN_PROGRAM_COUNTER_RST, 32'hffff_ffff);
    rdx(8'h1c, 32'h0, 32'hffff_ffff);
    // category checks with (a1) operand
    setreg(4'h9, a_val);
    wr(REG_OPWORD, 32'h11);
    for (int i = 0; i < 4; i++) begin
      op(8'h4, CLS_ANY, 1'b0, i == 0 ? KIND_EVAL : (i == 1 ? KIND_WPREV : KIND_TAKE),
        i == 3, 1'b1, 1'b1);
      res(i == 3 ? RES_OK : RES_PV);
    end
    check("take_addr", m_first, TAKE_A);
    check("take_fc", {29'h0, m_fc}, {29'h0, FC_SUP_DATA});
    ev(8'h0, 1'b0);
    res(RES_OK);
    check("len0_parts", m_cnt, 0);
    // every class code against a data register operand
    setreg(4'h0, 32'h1111_1111);
    wr(REG_OPWORD, 32'h0);
    for (int c = 0; c < 8; c++) begin
      op(8'h1, c[2:0], 1'b1, KIND_EVAL, 1'b1, 1'b0, 1'b0);
      res(c[0] ? RES_OK : RES_FLINE);
    end
    check("abort_mask", ab_data, ABORT_MASK);
    getreg(4'h0, 32'h1111_11f0);
    ev(8'h3, 1'b1);
    res(RES_PV);
    wr(REG_OPWORD, 32'h0a);
    ev(8'h2, 1'b1);
    getreg(4'ha, 32'hffff_80f0);
    // immediate length and direction, then unalterable pc-relative write
    wr(REG_OPWORD, 32'h3c);
    ev(8'h2, 1'b1);
    res(RES_PV);
    ev(8'h3, 1'b0);
    res(RES_PV);
    ev(8'h2, 1'b0);
    res(RES_OK);
    wr(REG_OPWORD, 32'h3a);
    ev(8'h4, 1'b1);
    res(RES_PV);
    // stack pointer byte steps of two
    setreg(4'hf, a_val);
    wr(REG_OPWORD, 32'h1f);
    ev(8'h1, 1'b0);
    check("postinc_addr", m_first, a_val);
    getreg(4'hf, a_val + 32'h2);
    wr(REG_OPWORD, 32'h27);
    ev(8'h1, 1'b0);
    check("predec_addr", m_first, a_val);
    getreg(4'hf, a_val);
    // displacement mode, longest operand, repeated issue
    wr(REG_SCAN_PROGRAM_COUNTER, 32'h100);
    wr(REG_OPWORD, 32'h29);
    ev(8'hff, 1'b0);
    check("long_parts", m_cnt, 64);
    check("tail_size", {29'h0, m_size}, 32'h3);
    check("ea_addr", m_first, a_val + 32'h10);
    check("rd_dir", {31'h0, m_we}, 32'h0);
    rdx(REG_SCAN_PROGRAM_COUNTER, 32'h102, 32'hffff_ffff);
    ev(8'h4, 1'b0);
    rdx(REG_SCAN_PROGRAM_COUNTER, 32'h104, 32'hffff_ffff);
    // taken address leaves the stored one alone; write-previous reuses it
    op(8'h4, CLS_ANY, 1'b1, KIND_TAKE, 1'b1, 1'b0, 1'b1);
    check("take_wr", {31'h0, m_we}, 32'h1);
    rdx(REG_TEMPEA, a_val + 32'h10, 32'hffff_ffff);
    op(8'h4, CLS_ANY, 1'b0, KIND_WPREV, 1'b1, 1'b0, 1'b0);
    check("wprev_addr", m_first, a_val + 32'h10);
    check("wprev_fc", {29'h0, m_fc}, {29'h0, FC_USER_DATA});
    getreg(4'h9, a_val);
    rdx(REG_SCAN_PROGRAM_COUNTER, 32'h104, 32'hffff_ffff);
    print_verdict();
  end
endmodule
